// File: core/lar_pkg.sv
// package of constants for the linear array readout sequencer
package lar_pkg;
    localparam int PIXEL_COUNT = 64;
    localparam int IDX_W = 7;
    localparam logic [IDX_W-1:0] LAST_STAGE = 7'h3F;
    localparam logic [IDX_W-1:0] IDLE_INDEX = 7'h00;
    localparam logic [PIXEL_COUNT-1:0] CHAIN_RESET = 64'h0;
    localparam int CLK_PERIOD_NS = 40;
endpackage

// File: core/lar_chain_if.sv
// interface carrying the token chain between sequencer and shift register
`timescale 1ns/1ns
interface lar_chain_if #(parameter int N = 64);
    logic load;
    logic [N-1:0] stages;
    logic [N-1:0] falling;
    modport src (output load, input stages, input falling);
    modport chain (input load, output stages, output falling);
endinterface

// File: core/lar_token_chain.sv
// token shift register with per-stage falling edge detection
`timescale 1ns/1ns
module lar_token_chain #(
    parameter int N = 64
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // chain signals
    lar_chain_if.chain chain
);
    import lar_pkg::*;

    logic [N-1:0] stage_ff;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage_ff <= '0;
        end else begin
            stage_ff <= {stage_ff[N-2:0], chain.load};
        end
    end

    assign chain.stages = stage_ff;
    // a stage drops when its token moves on
    assign chain.falling = stage_ff & ~{stage_ff[N-2:0], chain.load};
endmodule

// File: core/lar_sequencer.sv
// readout sequencer of the 64-pixel linear array
`timescale 1ns/1ns
module lar_sequencer #(
    parameter int N = lar_pkg::PIXEL_COUNT
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // controller pins
    input wire logic start_i,
    // analog switch controls
    output logic pixel_analog_out_oe_o,
    output logic [lar_pkg::IDX_W-1:0] pixel_sel_o,
    output logic [N-1:0] pixel_select_o,
    output logic [N-1:0] integ_reset_o,
    output logic [N-1:0] sample_connect_o,
    output logic cycle_busy_o
);
    import lar_pkg::*;

    lar_chain_if #(.N(N)) chain ();

    lar_token_chain #(.N(N)) u_chain (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .chain(chain.chain)
    );

    function automatic logic [IDX_W-1:0] one_hot_index(
        input logic [N-1:0] v
    );
        logic [IDX_W-1:0] r;
        r = IDLE_INDEX;
        for (int i = 0; i < N; i++) begin
            if (v[i]) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // next value of the token chain, one edge ahead of the register
    logic [N-1:0] nxt_stages;
    assign chain.load = start_i;
    assign nxt_stages = {chain.stages[N-2:0], start_i};

    logic oe_ff;
    logic [IDX_W-1:0] sel_ff;
    logic [N-1:0] select_ff;
    logic [N-1:0] ireset_ff;
    logic [N-1:0] sconn_ff;
    logic busy_ff;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            select_ff <= CHAIN_RESET;
            sel_ff <= IDLE_INDEX;
        end else begin
            select_ff <= nxt_stages;
            sel_ff <= one_hot_index(nxt_stages);
        end
    end

    // drives only while a stage holds the token; 65th edge clears it
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= |nxt_stages;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ireset_ff <= CHAIN_RESET;
        end else begin
            ireset_ff <= chain.stages & ~nxt_stages;
        end
    end

    // capacitor follows integrator except while its pixel is read out
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sconn_ff <= ~CHAIN_RESET;
        end else begin
            sconn_ff <= ~nxt_stages;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= |nxt_stages;
        end
    end

    assign pixel_analog_out_oe_o = oe_ff;
    assign pixel_sel_o = sel_ff;
    assign pixel_select_o = select_ff;
    assign integ_reset_o = ireset_ff;
    assign sample_connect_o = sconn_ff;
    assign cycle_busy_o = busy_ff;
endmodule

// File: verification/lar_ctrl_model.sv
// controller model: registers the request onto start, one edge later and as long as it is held
`timescale 1ns/1ns
module lar_ctrl_model (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic go_i,
    output logic start_o
);
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) start_o <= 1'b0;
        else start_o <= go_i;
    end
endmodule

// File: verification/lar_sequencer_chk.sv
// port checker of the readout sequencer
`timescale 1ns/1ns
module lar_sequencer_chk (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic pixel_analog_out_oe_o,
    input wire logic [63:0] pixel_select_o,
    input wire logic [63:0] integ_reset_o,
    input wire logic [63:0] sample_connect_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    a_start_loads: assert property (
        start_i && !pixel_analog_out_oe_o |=> pixel_select_o[0])
        else $error("start not loaded");
    a_token_shift: assert property (
        |pixel_select_o[62:0] |=>
        pixel_select_o[63:1] == $past(pixel_select_o[62:0]))
        else $error("token did not shift");
    a_reset_on_drop: assert property (
        integ_reset_o == ($past(pixel_select_o) & ~pixel_select_o))
        else $error("integrator reset wrong");
    a_token_exit: assert property (
        $rose(pixel_analog_out_oe_o) |-> ##63 pixel_analog_out_oe_o
        ##1 !pixel_analog_out_oe_o) else $error("cycle length wrong");
    a_idle_float: assert property (
        pixel_analog_out_oe_o == (|pixel_select_o))
        else $error("output driven while idle");
    a_cap_open: assert property (
        sample_connect_o == ~pixel_select_o) else $error("capacitor wrong");
    cover property ($rose(pixel_analog_out_oe_o));
    cover property ($fell(pixel_select_o[63]));
    cover property (start_i && !pixel_analog_out_oe_o);
endmodule
bind lar_sequencer lar_sequencer_chk u_chk (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .start_i(start_i), .integ_reset_o(integ_reset_o),
    .pixel_analog_out_oe_o(pixel_analog_out_oe_o),
    .pixel_select_o(pixel_select_o), .sample_connect_o(sample_connect_o));

// File: verification/lar_sequencer_tb_top.sv
// testbench of the readout sequencer
`timescale 1ns/1ns
module lar_sequencer_tb_top;
    logic clock_i = 0, rst_b_i = 0, go = 0, start_i, oe, busy;
    logic [6:0] sel;
    logic [63:0] psel, irst, scon, e;
    int errors = 0, comparisons = 0;
    lar_ctrl_model u_ctl (.clock_i(clock_i), .rst_b_i(rst_b_i), .go_i(go),
        .start_o(start_i));
    lar_sequencer dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .start_i(start_i), .pixel_analog_out_oe_o(oe), .pixel_sel_o(sel),
        .pixel_select_o(psel), .integ_reset_o(irst),
        .sample_connect_o(scon), .cycle_busy_o(busy));
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    task automatic check(input string n, input logic [63:0] s, x);
        comparisons++;
        if (s !== x) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    // a cycle; again asks for the next start at the 64th edge
    task automatic run(input bit pulse, input bit again);
        for (int k = pulse ? -1 : 1; k <= 65; k++) begin
            @(posedge clock_i);
            go <= (k == -1) || (k == 64 && again);
            #1;
            if (k < 1) continue;
            e = k <= 64 ? 64'h1 << (k - 1) : 64'h0;
            check("select", psel, e);
            check("index", 64'(sel), k <= 64 ? 64'(k - 1) : 64'h0);
            check("drive", 64'({oe, busy}), k <= 64 ? 64'h3 : 64'h0);
            check("ireset", irst, k >= 2 ? 64'h1 << (k - 2) : 64'h0);
            check("sample", scon, ~e);
        end
        $display("cycle test done");
    endtask
    task end_sim;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        run(1, 0);
        run(1, 1);
        run(0, 0);
        end_sim;
    end
endmodule
